// ---- flash_cmd_pkg.sv ----
// Constants, register map and types for the flash command controller
// ****************************************************************
// What this block does
// (R1) Buffer-empty flag clears only on written one
// (R2) Zero to buffer-empty mid-sequence aborts, flags access
// (R3) Buffer-empty with its enable requests interrupt
// (R4) Complete flag clear while buffer-empty clear
// (R5) Fetching a waiting command keeps complete clear
// (R6) Complete flag ignores writes; enable raises interrupt
// (R7) Normal modes: fail and done read zero
// (R8) Special modes: fail writable, done read-only
// (R9) Master clears fail before a special-mode sequence
// (R10) Sector erase clears one 1024-byte sector
// (R11) Sector erase ignores data and address bits 9:0
// (R12) Master writes 0x40 then launches sector erase
// (R13) Protected sector sets violation, no launch
// (R14) Complete sets after erase unless another buffered
// (R15) Mass erase uses 0x41, erases whole array
// (R16) Any protection blocks mass erase with violation
// (R17) Only 0x05, 0x20, 0x40, 0x41 accepted
// (R18) Factory-test register reads zero, ignores writes
// (R19) High range size codes: 2K, 4K, 8K, 16K
// (R20) Each algorithm is a counted busy period
// ****************************************************************
package flash_cmd_pkg;
    localparam int ADDR_W = 8;
    localparam int IDX_W = 6;
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PROT = 6'h03;
    localparam logic [IDX_W-1:0] IDX_CONFIG = 6'h04;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h05;
    localparam logic [IDX_W-1:0] IDX_CMD = 6'h06;
    localparam logic [IDX_W-1:0] IDX_RSVD = 6'h07;
    localparam logic [IDX_W-1:0] IDX_ADDR = 6'h08;
    localparam logic [IDX_W-1:0] IDX_ARRAY = 6'h09;
    // Status bits
    localparam int ST_BUF_EMPTY = 7;
    localparam int ST_COMPLETE = 6;
    localparam int ST_PROT_VIOL = 5;
    localparam int ST_ACC_ERR = 4;
    localparam int ST_BLANK = 2;
    localparam int ST_FAIL = 1;
    localparam int ST_DONE = 0;
    // Configuration bits
    localparam int CF_EMPTY_IE = 7;
    localparam int CF_COMPLETE_IE = 6;
    localparam int CF_SPECIAL = 0;
    // Protection bits
    localparam int PR_OPEN = 7;
    localparam int PR_HDIS = 5;
    localparam int PR_SIZE_LO = 3;
    // Commands
    localparam logic [7:0] CMD_VERIFY = 8'h05;
    localparam logic [7:0] CMD_PROGRAM = 8'h20;
    localparam logic [7:0] CMD_SECTOR = 8'h40;
    localparam logic [7:0] CMD_MASS = 8'h41;
    // Sector is 1024 bytes, so bits 9:0 do not select it
    localparam int SECTOR_LSB = 10;
    localparam logic [15:0] HIGH_BASE_2K = 16'hF800;
    localparam logic [15:0] HIGH_BASE_4K = 16'hF000;
    localparam logic [15:0] HIGH_BASE_8K = 16'hE000;
    localparam logic [15:0] HIGH_BASE_16K = 16'hC000;
    localparam int BUSY_CYCLES_DEF = 16;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [7:0] PROT_RESET = 8'h00;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ADDR = 2'b01,
        SEQ_CMD = 2'b10
    } seq_e;
endpackage

// ---- flash_command_controller.sv ----
// Flash command controller with AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module flash_command_controller
    import flash_cmd_pkg::*;
#(
    parameter int busy_cycles = BUSY_CYCLES_DEF
)(
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic flash_irq,
    output logic erase_busy
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        seq_e seq;
        logic buffer_empty_flag, command_complete_flag, erased_all;
        logic protection_violation_flag, access_error_flag, fail, blank;
        logic buffer_empty_irq_enable, command_complete_irq_enable, special;
        logic prot_open, prot_hdis;
        logic [1:0] high_range_size;
        logic [15:0] flash_address_latch;
        logic [7:0] command_code_bits;
        logic pend;
        logic [7:0] pend_cmd;
        logic busy;
        logic [7:0] act_cmd;
        logic [15:0] busy_cnt;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    localparam logic [15:0] BUSY_LOAD = 16'(busy_cycles - 1);
    logic wr_fire, wr_lane0, wr_stat, wr_cmd, wr_array, wr_hit, launch;
    logic sector_prot, any_prot, cmd_valid, rd_hit, fin;
    logic [IDX_W-1:0] wr_idx, rd_idx;
    logic [7:0] wd, stat_word;
    logic [15:0] high_base;
    logic [31:0] rd_word;

    // ************************************************************
    // Decode and protection
    // ************************************************************
    assign wr_fire = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    assign wr_idx = s_r.aw_addr[ADDR_W-1:2];
    assign wr_lane0 = s_r.w_strb[0];
    assign wd = s_r.w_data[7:0];
    assign rd_idx = s_axi_araddr[ADDR_W-1:2];
    assign fin = s_r.busy && (s_r.busy_cnt == 16'h0000);

    always_comb
    begin
        wr_hit = 1'b1;
        wr_stat = 1'b0;
        wr_cmd = 1'b0;
        wr_array = 1'b0;
        if (s_r.aw_addr[1:0] != 2'b00)
            wr_hit = 1'b0;
        else if (wr_idx == IDX_STATUS)
            wr_stat = wr_fire && wr_lane0;
        else if (wr_idx == IDX_CMD)
            wr_cmd = wr_fire && wr_lane0;
        else if (wr_idx == IDX_ARRAY)
            wr_array = wr_fire && wr_lane0;
        else if (wr_idx == IDX_PROT || wr_idx == IDX_CONFIG
            || wr_idx == IDX_RSVD || wr_idx == IDX_ADDR)
            wr_hit = 1'b1;
        else
            wr_hit = 1'b0;
    end
    always_comb
    begin
        case (s_r.high_range_size) // R19
            2'b00: high_base = HIGH_BASE_2K;
            2'b01: high_base = HIGH_BASE_4K;
            2'b10: high_base = HIGH_BASE_8K;
            default: high_base = HIGH_BASE_16K;
        endcase
    end
    // Only the sector bits take part; the low bits are ignored
    always_comb
    begin
        logic in_high;
        in_high = s_r.flash_address_latch[15:SECTOR_LSB]
            >= high_base[15:SECTOR_LSB]; // R11
        if (s_r.prot_open)
            sector_prot = !s_r.prot_hdis && in_high; // R13
        else
            sector_prot = s_r.prot_hdis || !in_high; // R13
    end
    assign any_prot = !(s_r.prot_open && s_r.prot_hdis); // R16
    assign cmd_valid = (wd == CMD_VERIFY) || (wd == CMD_PROGRAM)
        || (wd == CMD_SECTOR) || (wd == CMD_MASS); // R17
    assign launch = wr_stat && wd[ST_BUF_EMPTY] && s_r.seq == SEQ_CMD;
    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb
    begin
        stat_word = 8'h00;
        stat_word[ST_BUF_EMPTY] = s_r.buffer_empty_flag;
        stat_word[ST_COMPLETE] = s_r.command_complete_flag;
        stat_word[ST_PROT_VIOL] = s_r.protection_violation_flag;
        stat_word[ST_ACC_ERR] = s_r.access_error_flag;
        stat_word[ST_BLANK] = s_r.blank;
        // Fail and done are hidden outside special modes
        stat_word[ST_FAIL] = s_r.special && s_r.fail; // R7 R8
        stat_word[ST_DONE] = s_r.special && !s_r.busy; // R7 R8
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (s_axi_araddr[1:0] != 2'b00)
            rd_hit = 1'b0;
        else if (rd_idx == IDX_STATUS)
            rd_word[7:0] = stat_word;
        else if (rd_idx == IDX_CONFIG)
        begin
            rd_word[CF_EMPTY_IE] = s_r.buffer_empty_irq_enable;
            rd_word[CF_COMPLETE_IE] = s_r.command_complete_irq_enable;
            rd_word[CF_SPECIAL] = s_r.special;
        end
        else if (rd_idx == IDX_PROT)
        begin
            rd_word[PR_OPEN] = s_r.prot_open;
            rd_word[PR_HDIS] = s_r.prot_hdis;
            rd_word[PR_SIZE_LO+1:PR_SIZE_LO] = s_r.high_range_size;
        end
        else if (rd_idx == IDX_CMD)
            rd_word[7:0] = s_r.command_code_bits;
        else if (rd_idx == IDX_ADDR)
            rd_word[15:0] = s_r.flash_address_latch;
        else if (rd_idx == IDX_RSVD || rd_idx == IDX_ARRAY)
            rd_word = 32'h0000_0000; // R18
        else
            rd_hit = 1'b0;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_nxt = s_r;
        if (s_axi_awvalid && !s_r.aw_held)
        begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_held)
        begin
            s_nxt.w_held = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready)
            s_nxt.bvalid = 1'b0;
        if (s_r.rvalid && s_axi_rready)
            s_nxt.rvalid = 1'b0;
        if (s_axi_arvalid && !s_r.rvalid)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_word;
            s_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        // Erase engine: completion, then fetch of a waiting command
        if (fin)
        begin
            s_nxt.busy = 1'b0;
            if (s_r.act_cmd == CMD_MASS)
                s_nxt.erased_all = 1'b1; // R15
            else if (s_r.act_cmd == CMD_PROGRAM)
                s_nxt.erased_all = 1'b0;
            else if (s_r.act_cmd == CMD_VERIFY)
                s_nxt.blank = s_r.erased_all;
            if (!s_r.pend)
                s_nxt.command_complete_flag = 1'b1; // R14
        end
        if (s_r.pend && (!s_r.busy || fin))
        begin
            // Complete flag is left alone here so it stays clear
            s_nxt.busy = 1'b1; // R5
            s_nxt.act_cmd = s_r.pend_cmd; // R10 R15
            s_nxt.busy_cnt = BUSY_LOAD; // R20
            s_nxt.pend = 1'b0;
            s_nxt.buffer_empty_flag = 1'b1;
        end
        else if (s_r.busy && !fin)
            s_nxt.busy_cnt = s_r.busy_cnt - 16'h0001; // R20
        if (wr_fire)
        begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
            if (wr_lane0 && wr_idx == IDX_CONFIG)
            begin
                s_nxt.buffer_empty_irq_enable = wd[CF_EMPTY_IE];
                s_nxt.command_complete_irq_enable = wd[CF_COMPLETE_IE];
                s_nxt.special = wd[CF_SPECIAL];
            end
            if (wr_lane0 && wr_idx == IDX_PROT)
            begin
                s_nxt.prot_open = wd[PR_OPEN];
                s_nxt.prot_hdis = wd[PR_HDIS];
                if (wd[PR_HDIS] || s_r.prot_hdis)
                    s_nxt.high_range_size = wd[PR_SIZE_LO+1:PR_SIZE_LO];
            end
            if (wr_lane0 && wr_idx == IDX_ADDR)
                s_nxt.flash_address_latch[7:0] = wd;
            if (s_r.w_strb[1] && wr_idx == IDX_ADDR)
                s_nxt.flash_address_latch[15:8] = s_r.w_data[15:8];
        end

        // Error flags clear first so a same-cycle set wins
        if (wr_stat)
        begin
            if (wd[ST_PROT_VIOL])
                s_nxt.protection_violation_flag = 1'b0;
            if (wd[ST_ACC_ERR])
                s_nxt.access_error_flag = 1'b0;
            if (s_r.special)
                s_nxt.fail = wd[ST_FAIL]; // R8
            if (launch)
            begin
                s_nxt.seq = SEQ_IDLE;
                if ((s_r.command_code_bits == CMD_SECTOR && sector_prot)
                    || (s_r.command_code_bits == CMD_MASS && any_prot))
                    s_nxt.protection_violation_flag = 1'b1; // R13 R16
                else
                begin
                    s_nxt.pend = 1'b1;
                    s_nxt.pend_cmd = s_r.command_code_bits;
                    s_nxt.buffer_empty_flag = 1'b0; // R1
                end
            end
            else if (s_r.seq != SEQ_IDLE)
            begin
                // Zero aborts; a one before the command is out of order
                s_nxt.seq = SEQ_IDLE;
                s_nxt.access_error_flag = 1'b1; // R2
            end
        end
        if (wr_array)
        begin
            if (s_r.buffer_empty_flag && s_r.seq == SEQ_IDLE)
            begin
                s_nxt.flash_address_latch = s_r.w_data[31:16]; // R11
                s_nxt.seq = SEQ_ADDR;
            end
            else
            begin
                s_nxt.seq = SEQ_IDLE;
                s_nxt.access_error_flag = 1'b1;
            end
        end
        if (wr_cmd)
        begin
            if (s_r.seq == SEQ_ADDR && cmd_valid)
            begin
                s_nxt.command_code_bits = wd;
                s_nxt.seq = SEQ_CMD;
            end
            else
            begin
                s_nxt.seq = SEQ_IDLE;
                s_nxt.access_error_flag = 1'b1; // R17
            end
        end
        // Complete flag follows buffer-empty down; writes never reach it
        s_nxt.command_complete_flag = s_nxt.command_complete_flag
            && s_nxt.buffer_empty_flag; // R4 R6
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.buffer_empty_flag <= 1'b1;
            s_r.command_complete_flag <= 1'b1;
            {s_r.prot_open, s_r.prot_hdis} <= {PROT_RESET[PR_OPEN],
                PROT_RESET[PR_HDIS]};
        end
        else
            s_r <= s_nxt;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign s_axi_awready = !s_r.aw_held;
    assign s_axi_wready = !s_r.w_held;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign erase_busy = s_r.busy;
    assign flash_irq =
        (s_r.buffer_empty_flag && s_r.buffer_empty_irq_enable) // R3
        || (s_r.command_complete_flag
            && s_r.command_complete_irq_enable); // R6

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    chk_empty_zero_keeps: assert property ( // R1
        wr_stat && !wd[ST_BUF_EMPTY] && s_r.buffer_empty_flag
        |=> s_r.buffer_empty_flag)
        else $error("buffer-empty flag cleared by a zero");
    chk_abort_sets_error: assert property ( // R2
        wr_stat && !wd[ST_BUF_EMPTY] && s_r.seq != SEQ_IDLE
        |=> s_r.access_error_flag && s_r.seq == SEQ_IDLE)
        else $error("abort did not flag access error");
    chk_empty_irq: assert property ( // R3
        s_r.buffer_empty_flag && s_r.buffer_empty_irq_enable
        |-> flash_irq)
        else $error("buffer-empty interrupt missing");
    chk_complete_follows: assert property ( // R4
        !s_r.buffer_empty_flag |-> !s_r.command_complete_flag)
        else $error("complete flag set while buffer full");
    chk_fetch_keeps_complete: assert property ( // R5
        fin && s_r.pend |=> !s_r.command_complete_flag ##1
        !s_r.command_complete_flag)
        else $error("complete flag set on fetch");
    chk_complete_write_ignored: assert property ( // R6
        wr_stat && wd[ST_COMPLETE] && s_r.busy && s_r.busy_cnt > 16'h0001
        |=> !s_r.command_complete_flag)
        else $error("write reached complete flag");
    chk_normal_hides_bits: assert property ( // R7
        !s_r.special |-> stat_word[ST_FAIL:ST_DONE] == 2'b00)
        else $error("fail or done visible in normal mode");
    chk_sector_protect: assert property ( // R13
        launch && s_r.command_code_bits == CMD_SECTOR && sector_prot
        |=> s_r.protection_violation_flag && !s_r.pend)
        else $error("protected sector erase launched");
    chk_mass_protect: assert property ( // R16
        launch && s_r.command_code_bits == CMD_MASS && any_prot
        |=> s_r.protection_violation_flag && !s_r.pend && !$rose(s_r.busy))
        else $error("protected mass erase launched");
    chk_bad_code: assert property ( // R17
        wr_cmd && !cmd_valid |=> s_r.access_error_flag)
        else $error("invalid command not flagged");
    chk_reserved_zero: assert property ( // R18
        s_axi_arvalid && !s_r.rvalid && rd_idx == IDX_RSVD
        && s_axi_araddr[1:0] == 2'b00 |=> s_r.rdata == 32'h0000_0000)
        else $error("reserved register read nonzero");
    chk_busy_window: assert property ( // R20
        $rose(s_r.busy) |-> (!s_r.command_complete_flag && s_r.busy)[*8])
        else $error("busy period too short");

    cov_sector_done: cover property (
        s_r.busy && s_r.act_cmd == CMD_SECTOR ##1 !s_r.busy
        && s_r.command_complete_flag);
    cov_mass_done: cover property (
        fin && s_r.act_cmd == CMD_MASS);
    cov_back_to_back: cover property (fin && s_r.pend);
    cov_access_error: cover property ($rose(s_r.access_error_flag));
endmodule
`default_nettype wire

// ---- flash_cpu_master.sv ----
// CPU-side AXI4-Lite master that issues flash command sequences
`timescale 1ns/100ps
`default_nettype none
module flash_cpu_master
    import flash_cmd_pkg::*;
(
    input wire logic clock,
    output logic [ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // ****************
    // Bus cycles
    // ****************
    int hung = 0;
    initial
    begin
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'h0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'h0;
        s_axi_bready = 1'h0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'h0;
        s_axi_rready = 1'h0;
    end
    // Released address and data lines show the inverse so a stale value is never reused
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int n = 0; n < 64; n++)
        begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awvalid <= 1'h0;
                s_axi_awaddr <= ~s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wvalid <= 1'h0;
                s_axi_wdata <= ~s_axi_wdata;
            end
            if (s_axi_bvalid)
            begin
                s_axi_bready <= 1'h0;
                return;
            end
        end
        hung++;
    endtask
    task automatic rd(input logic [IDX_W-1:0] idx);
        @(posedge clock);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int n = 0; n < 64; n++)
        begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arvalid <= 1'h0;
                s_axi_araddr <= ~s_axi_araddr;
            end
            if (s_axi_rvalid)
            begin
                s_axi_rready <= 1'h0;
                return;
            end
        end
        hung++;
    endtask
endmodule
`default_nettype wire

// ---- tb_flash_command_controller.sv ----
// Self-checking bench for the flash command controller
`timescale 1ns/100ps
`default_nettype none
module tb_flash_command_controller;
    import flash_cmd_pkg::*;
    // Long enough that a second sequence is buffered while one runs
    localparam int busy_len = 20;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, flash_irq, erase_busy;
    logic [33:0] exp_r [$];
    logic [1:0] exp_b [$];
    logic [31:0] seed = 32'h0000_7950;
    int mismatches = 0;
    int n_compared = 0;
    int busy_cnt = 0;
    logic [7:0] codes [8] = '{CMD_VERIFY, CMD_PROGRAM, CMD_SECTOR,
        CMD_MASS, 8'h00, 8'h42, 8'hff, 8'h21};
    logic [15:0] bases [4] = '{HIGH_BASE_2K, HIGH_BASE_4K, HIGH_BASE_8K,
        HIGH_BASE_16K};

    flash_command_controller #(.busy_cycles(busy_len))
        flash_command_controller_i (
        .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .flash_irq, .erase_busy);
    flash_cpu_master flash_cpu_master_i (
        .clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

    always #12.5 clock = ~clock;

    // ****************
    // Helpers
    // ****************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [33:0] seen, input logic [33:0] e);
        n_compared++;
        if (seen !== e)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, e);
        end
    endtask
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic guard();
        if (flash_cpu_master_i.hung != 0)
        begin
            mismatches++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d,
        input logic [1:0] r = RESP_OKAY);
        exp_b.push_back(r);
        flash_cpu_master_i.wr(idx, d);
        guard();
    endtask
    task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] e,
        input logic [1:0] r = RESP_OKAY);
        exp_r.push_back({r, e});
        flash_cpu_master_i.rd(idx);
        guard();
    endtask
    task automatic st(input logic [7:0] e);
        rd(IDX_STATUS, 32'(e));
    endtask
    // Low address bits and data are random since the sector ignores them
    task automatic go(input logic [15:0] a, input logic [7:0] c);
        wr(IDX_ARRAY, {a | (16'(rnd()) & 16'h03ff), 16'(rnd())});
        wr(IDX_CMD, 32'(c));
        wr(IDX_STATUS, 32'h0000_0080);
    endtask
    task automatic fin(input int len, input int e);
        repeat (len) @(posedge clock);
        check(34'(busy_cnt), 34'(e));
        busy_cnt = 0;
    endtask
    always @(posedge clock)
    begin
        busy_cnt += int'(erase_busy === 1'h1);
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            check(34'(s_axi_bresp), 34'(exp_b.pop_front()));
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        complete_run();
    end

    // ****************
    // Scenarios
    // ****************
    initial
    begin
        repeat (5) @(posedge clock);
        rst <= 1'h0;
        st(8'hc0);
        rd(IDX_PROT, 32'(PROT_RESET));
        check(34'({flash_irq, erase_busy}), 34'h0);
        wr(IDX_RSVD, 32'hffff_ffff);
        rd(IDX_RSVD, 32'h0000_0000);
        wr(6'h0a, 32'hffff_ffff, RESP_SLVERR);
        rd(6'h0a, 32'h0000_0000, RESP_SLVERR);
        wr(IDX_STATUS, 32'h0000_004f);
        st(8'hc0);
        foreach (codes[i])
        begin
            wr(IDX_ARRAY, rnd());
            wr(IDX_CMD, 32'(codes[i]));
            st(i < 4 ? 8'hc0 : 8'hd0);
            wr(IDX_STATUS, 32'h0000_0000);
            if (i < 4)
                st(8'hd0);
            wr(IDX_STATUS, 32'h0000_0010);
        end
        st(8'hc0);
        foreach (bases[s])
        begin
            wr(IDX_PROT, 32'({3'h1, 2'(s), 3'h0}));
            wr(IDX_PROT, 32'({2'(s), 3'h0}));
            rd(IDX_PROT, 32'({2'(s), 3'h0}));
            go(bases[s], CMD_SECTOR);
            fin(busy_len + 8, busy_len);
            st(8'hc0);
            go(bases[s] - 16'h0400, CMD_SECTOR);
            fin(8, 0);
            st(8'he0);
            wr(IDX_STATUS, 32'h0000_0020);
        end
        go(16'(rnd()), CMD_MASS);
        fin(8, 0);
        st(8'he0);
        wr(IDX_STATUS, 32'h0000_0020);
        wr(IDX_PROT, 32'h0000_00a0);
        go(16'(rnd()), CMD_MASS);
        fin(busy_len + 8, busy_len);
        go(16'hf800, CMD_SECTOR);
        go(16'hfc00, CMD_SECTOR);
        st(8'h00);
        fin(2 * busy_len + 8, 2 * busy_len);
        st(8'hc0);
        wr(IDX_CONFIG, 32'h0000_0041);
        wr(IDX_STATUS, 32'h0000_0002);
        st(8'hc3);
        wr(IDX_STATUS, 32'h0000_0000);
        st(8'hc1);
        go(16'hf800, CMD_SECTOR);
        wr(IDX_STATUS, 32'h0000_0041);
        st(8'h80);
        check(34'(flash_irq), 34'h0);
        wr(IDX_CONFIG, 32'h0000_0081);
        check(34'(flash_irq), 34'h1);
        fin(busy_len + 8, busy_len);
        wr(IDX_CONFIG, 32'h0000_0041);
        check(34'(flash_irq), 34'h1);
        st(8'hc1);
        go(16'(rnd()), CMD_VERIFY);
        fin(busy_len + 8, busy_len);
        st(8'hc5);
        go(16'(rnd()), CMD_PROGRAM);
        go(16'(rnd()), CMD_VERIFY);
        fin(2 * busy_len + 8, 2 * busy_len);
        st(8'hc1);
        complete_run();
    end
endmodule
`default_nettype wire
